// ---- hw/asc_host.sv ----
// host controller that drives a 512k by 8 asynchronous static memory through its pins
`timescale 1ns/1ps
module asc_host
    import asc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_loc,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic rsp_valid,
    output logic [ADDR_W-1:0] loc_idx,
    output logic cs_n,
    output logic store_n,
    output logic oe_n,
    input wire logic [DATA_W-1:0] io_byte_i,
    output logic [DATA_W-1:0] io_byte_o,
    output logic io_byte_oe
);
    asc_state_e state_r;
    logic wr_r;
    logic [DATA_W-1:0] rd_meta_r;
    logic [DATA_W-1:0] rd_sync_r;
    logic t_load;
    logic [CNT_W-1:0] t_val;
    logic t_done;

    // ------------------------------------------------------------
    // pin data path
    // ------------------------------------------------------------
    // read data come from another timing world, so two flops before use
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_meta_r <= 8'h00;
            rd_sync_r <= 8'h00;
        end else begin
            rd_meta_r <= io_byte_i;
            rd_sync_r <= rd_meta_r;
        end
    end

    asc_cycle_timer u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(t_load),
        .load_val(t_val),
        .done(t_done)
    );

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    assign req_ready = (state_r == ASC_IDLE);

    always_comb begin
        t_load = 1'b0;
        t_val = CNT_ZERO;
        unique case (state_r)
            ASC_IDLE: begin
                t_load = req_valid;
                t_val = SETUP_WAIT;
            end
            ASC_SETUP: begin
                t_load = t_done;
                t_val = wr_r ? RELEASE_WAIT : READ_WAIT;
            end
            // recovery keeps a minimum read cycle between locations
            ASC_RD_WAIT: begin
                t_load = t_done;
                t_val = RECOVER_WAIT;
            end
            ASC_WR_REL: begin
                t_load = t_done;
                t_val = STORE_WAIT;
            end
            ASC_WR_HOLD: begin
                t_load = t_done;
                t_val = RECOVER_WAIT;
            end
            ASC_RECOVER: begin
                t_load = 1'b0;
                t_val = CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= ASC_IDLE;
        end else begin
            unique case (state_r)
                ASC_IDLE: if (req_valid) state_r <= ASC_SETUP;
                ASC_SETUP: if (t_done) state_r <= wr_r ? ASC_WR_REL : ASC_RD_WAIT;
                ASC_RD_WAIT: if (t_done) state_r <= ASC_RECOVER;
                ASC_WR_REL: if (t_done) state_r <= ASC_WR_HOLD;
                ASC_WR_HOLD: if (t_done) state_r <= ASC_RECOVER;
                ASC_RECOVER: if (t_done) state_r <= ASC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // location and write data
    // ------------------------------------------------------------
    // hold location and data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_r <= 1'b0;
            loc_idx <= 19'h00000;
            io_byte_o <= 8'h00;
        end else if (state_r == ASC_IDLE && req_valid) begin
            wr_r <= req_write;
            loc_idx <= req_loc;
            io_byte_o <= req_wdata;
        end
    end

    // ------------------------------------------------------------
    // control pins
    // ------------------------------------------------------------
    // select falls last: location and output enable already set in setup
    // select high outside a cycle keeps the memory in standby
    // select rises a cycle after store, so no write is select-ended
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs_n <= 1'b1;
        end else begin
            cs_n <= !(state_r == ASC_RD_WAIT || state_r == ASC_WR_REL
                || state_r == ASC_WR_HOLD);
        end
    end

    // output enable leads select, so the select access interval governs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            oe_n <= 1'b1;
        end else begin
            oe_n <= !(!wr_r && (state_r == ASC_SETUP || state_r == ASC_RD_WAIT))
                || (state_r == ASC_RD_WAIT && t_done);
        end
    end

    // store low together with select writes the held byte
    // store rises while select still low ends the write
    // output enable stays high during writes so the pins are free
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            store_n <= 1'b1;
        end else begin
            store_n <= !(state_r == ASC_WR_REL || (state_r == ASC_WR_HOLD && !t_done));
        end
    end

    // drive data only after the release interval, counted from store falling
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            io_byte_oe <= 1'b0;
        end else begin
            io_byte_oe <= (state_r == ASC_WR_HOLD);
        end
    end

    // ------------------------------------------------------------
    // read return
    // ------------------------------------------------------------
    // sample after access interval plus the two synchroniser flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rsp_rdata <= 8'h00;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= (state_r == ASC_RD_WAIT) && t_done;
            if ((state_r == ASC_RD_WAIT) && t_done) begin
                rsp_rdata <= rd_sync_r;
            end
        end
    end
endmodule

// ---- hw/asc_pkg.sv ----
// constants shared by the static memory host controller
package asc_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_PS = 4000;
    // interval figures in picoseconds; access figures are longest times of the device
    localparam int MIN_READ_CYCLE_TIME_PS = 20000;
    localparam int ADDRESS_ACCESS_INTERVAL_PS = 25000;
    localparam int SELECT_ACCESS_INTERVAL_PS = 25000;
    localparam int OUTPUT_ENABLE_ACCESS_INTERVAL_PS = 10000;
    localparam int OUTPUT_RELEASE_INTERVAL_PS = 10000;
    localparam int STORE_PULSE_PS = 20000;
    localparam int SETUP_PS = 4000;
    // the host must wait at least these, so every count rounds up
    localparam int READ_WAIT_CYC = (ADDRESS_ACCESS_INTERVAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SEL_WAIT_CYC = (SELECT_ACCESS_INTERVAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RELEASE_CYC = (OUTPUT_RELEASE_INTERVAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STORE_CYC = (STORE_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETUP_CYC = (SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYCLE_CYC = (MIN_READ_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 4;
    // select falls one cycle after the load, then the access, then two synchroniser flops
    localparam logic [CNT_W-1:0] READ_WAIT = CNT_W'(((READ_WAIT_CYC > SEL_WAIT_CYC)
        ? READ_WAIT_CYC : SEL_WAIT_CYC) + 3);
    localparam logic [CNT_W-1:0] RELEASE_WAIT = CNT_W'(RELEASE_CYC);
    localparam logic [CNT_W-1:0] STORE_WAIT = CNT_W'(STORE_CYC);
    localparam logic [CNT_W-1:0] SETUP_WAIT = CNT_W'(SETUP_CYC);
    localparam logic [CNT_W-1:0] RECOVER_WAIT = CNT_W'(CYCLE_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    typedef enum logic [5:0] {
        ASC_IDLE    = 6'b000001,
        ASC_SETUP   = 6'b000010,
        ASC_RD_WAIT = 6'b000100,
        ASC_WR_REL  = 6'b001000,
        ASC_WR_HOLD = 6'b010000,
        ASC_RECOVER = 6'b100000
    } asc_state_e;
endpackage

// ---- hw/asc_cycle_timer.sv ----
// down counter that times the phases of one memory cycle
`timescale 1ns/1ps
module asc_cycle_timer
    import asc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    output logic done
);
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_r <= CNT_ZERO;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (cnt_r != CNT_ZERO) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end

    // done while the count shows its last step, so a load of n spans n cycles;
    // done must not look at load, which the sequencer makes from done
    assign done = (cnt_r <= 4'h1);
endmodule

// ---- sim/asc_sram_model.sv ----
// behavioural 512k by 8 asynchronous static memory seen from its pins
`timescale 1ns/1ps
module asc_sram_model
    import asc_pkg::*;
#(
    parameter int ACC_NS = ((ADDRESS_ACCESS_INTERVAL_PS > SELECT_ACCESS_INTERVAL_PS)
        ? ADDRESS_ACCESS_INTERVAL_PS : SELECT_ACCESS_INTERVAL_PS) / 1000
)(
    input wire logic cs_n,
    input wire logic store_n,
    input wire logic oe_n,
    input wire logic [ADDR_W-1:0] loc_idx,
    input wire logic [DATA_W-1:0] io_byte_o,
    input wire logic io_byte_oe,
    output logic [DATA_W-1:0] io_byte_i
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] word;
    realtime t_chg = 0;
    // access timed from the last location, select or enable change
    always @(loc_idx or cs_n or oe_n) t_chg = $realtime;
    // stepped between clock edges so the host never samples a byte mid-change
    initial #0.5 forever begin
        // store whenever select and store are low; an undriven bus stores unknown
        if (!cs_n && !store_n) mem[int'(loc_idx)] = io_byte_oe ? io_byte_o : 8'hxx;
        word = mem.exists(int'(loc_idx)) ? mem[int'(loc_idx)] : 8'h5a;
        // drive only when selected, enabled, not storing
        io_byte_i = io_byte_oe ? io_byte_o : ~word;
        if (!io_byte_oe && !(cs_n | oe_n | !store_n) && $realtime - t_chg >= ACC_NS)
            io_byte_i = word;
        #1;
    end
endmodule

// ---- sim/asc_host_sva.sv ----
// assertions on the memory pins of the host controller
`timescale 1ns/1ps
module asc_host_sva
    import asc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_loc,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic req_ready,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input wire logic rsp_valid,
    input wire logic [ADDR_W-1:0] loc_idx,
    input wire logic cs_n,
    input wire logic store_n,
    input wire logic oe_n,
    input wire logic [DATA_W-1:0] io_byte_i,
    input wire logic [DATA_W-1:0] io_byte_o,
    input wire logic io_byte_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_wr_go; req_valid && req_ready && req_write |-> ##[1:3] !(cs_n | store_n); endproperty
    a_wr_go: assert property (p_wr_go) else $error("write not begun");
    property p_rd_set; $fell(cs_n) && store_n |-> !$past(oe_n) && !oe_n; endproperty
    a_rd_set: assert property (p_rd_set) else $error("select before enable");
    property p_rd_hold; $fell(cs_n) && store_n |-> !(cs_n | oe_n) [*7]; endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read cut short");
    property p_rd_ans; req_valid && req_ready && !req_write |-> ##[8:16] rsp_valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
    property p_st_end; $rose(store_n) |-> !cs_n; endproperty
    a_st_end: assert property (p_st_end) else $error("write not store ended");
    property p_st_len; $fell(store_n) |-> !store_n [*5]; endproperty
    a_st_len: assert property (p_st_len) else $error("store pulse short");
    property p_release; $fell(store_n) |-> !io_byte_oe [*3]; endproperty
    a_release: assert property (p_release) else $error("data driven early");
    property p_stable;
        !cs_n ##1 !cs_n |-> $stable(loc_idx) && (store_n || $stable(io_byte_o));
    endproperty
    a_stable: assert property (p_stable) else $error("pins moved in cycle");
    c_rd: cover property (rsp_valid);
    c_wr: cover property ($rose(store_n) && !cs_n);
    c_sel: cover property ($fell(cs_n) && store_n);
endmodule
bind asc_host asc_host_sva i_asc_host_sva (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .req_valid(req_valid),
    .req_write(req_write),
    .req_loc(req_loc),
    .req_wdata(req_wdata),
    .req_ready(req_ready),
    .rsp_rdata(rsp_rdata),
    .rsp_valid(rsp_valid),
    .loc_idx(loc_idx),
    .cs_n(cs_n),
    .store_n(store_n),
    .oe_n(oe_n),
    .io_byte_i(io_byte_i),
    .io_byte_o(io_byte_o),
    .io_byte_oe(io_byte_oe)
);

// ---- sim/tb.sv ----
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("unexpected %s exp %h got %h", nm, e, a); end end
module tb;
    import asc_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [ADDR_W-1:0] req_loc = 19'h00000, loc_idx;
    logic [DATA_W-1:0] req_wdata = 8'h00, rsp_rdata, io_byte_i, io_byte_o;
    logic req_ready, rsp_valid, cs_n, store_n, oe_n, io_byte_oe;
    int fails = 0, checks = 0;
    always #2 ref_clk = ~ref_clk;
    asc_host i_asc_host (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .req_valid(req_valid),
        .req_write(req_write),
        .req_loc(req_loc),
        .req_wdata(req_wdata),
        .req_ready(req_ready),
        .rsp_rdata(rsp_rdata),
        .rsp_valid(rsp_valid),
        .loc_idx(loc_idx),
        .cs_n(cs_n),
        .store_n(store_n),
        .oe_n(oe_n),
        .io_byte_i(io_byte_i),
        .io_byte_o(io_byte_o),
        .io_byte_oe(io_byte_oe)
    );
    asc_sram_model i_asc_sram_model (
        .cs_n(cs_n),
        .store_n(store_n),
        .oe_n(oe_n),
        .loc_idx(loc_idx),
        .io_byte_o(io_byte_o),
        .io_byte_oe(io_byte_oe),
        .io_byte_i(io_byte_i)
    );
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // a hung handshake ends the run as a failure
    task automatic step(inout int n);
        n++;
        if (n > 40) fails++;
        if (n > 40) tally_and_finish;
        @(negedge ref_clk);
    endtask
    // for a read, d is the byte expected back
    task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n = 0;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_write = w;
        req_loc = a;
        req_wdata = d;
        while (req_ready !== 1'b1) step(n);
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (!w && rsp_valid !== 1'b1) step(n);
        if (!w) `CHK("rsp_rdata", d, rsp_rdata)
    endtask
    task automatic t_rw;
        logic [ADDR_W-1:0] la [4] = '{19'h00000, 19'h7ffff, 19'h12345, 19'h12344};
        logic [DATA_W-1:0] ld [4] = '{8'ha5, 8'h3c, 8'hff, 8'h00};
        foreach (la[i]) op(1'b1, la[i], ld[i]);
        foreach (la[i]) op(1'b0, la[i], ld[i]);
        op(1'b1, 19'h12345, 8'h69);
        op(1'b0, 19'h12345, 8'h69);
        op(1'b0, 19'h12344, 8'h00);
        $display("test write read end");
    endtask
    // reset lands in mid write; the pins must fall back to standby
    task automatic t_abort;
        op(1'b1, 19'h00100, 8'h77);
        repeat (3) @(negedge ref_clk);
        `CHK("store pins", 2'h0, {cs_n, store_n})
        rst_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK("pins", 5'h1d, {cs_n, store_n, oe_n, io_byte_oe, req_ready})
        rst_n = 1'b1;
        op(1'b0, 19'h7ffff, 8'h3c);
        $display("test abort end");
    endtask
    initial begin
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        t_rw;
        t_abort;
        tally_and_finish;
    end
endmodule
